// *** rtl/rfs_receive_config.sv ***
// receive configuration and start-of-frame detection
//
// Notes on behaviour
// - apply configuration only on request rising edge
// - applying configuration discards pending received data
// - settings volatile; reset restores stored defaults
// - reinit flag set by host, cleared by device
// - done pulses one cycle on clean completion
// - error pulses one cycle, status holds code
// - status reads 7000h out of reset
// - configuration holds start and end conditions
// - start found by all enabled conditions, as below
// - break first, then idle line, in order
// - then start char or sequence suffices
// - any-character condition never combined with others
// - one mask bit per condition, default 0002h
// - idle needs programmable bit times, default 0028h
`timescale 1ns/1ps
`include "rfs_defs.svh"

module rfs_receive_config #(
    parameter int SEQ_NUM = 4,
    parameter int SEQ_LEN = 5
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    // configuration request
    input  wire logic                     frame_receive_command,
    input  wire logic                     reinit_set,
    input  wire logic [15:0]              cfg_start_condition_mask,
    input  wire logic [15:0]              cfg_idle_bit_times,
    input  wire logic [7:0]               cfg_start_char,
    input  wire logic [7:0]               cfg_end_char,
    input  wire logic [SEQ_NUM*8-1:0]         cfg_seq_ctl,
    input  wire logic [SEQ_NUM*SEQ_LEN*8-1:0] cfg_seq_chars,
    // configuration answer
    output logic                          function_reinit_flag,
    output logic                          done,
    output logic                          error,
    output logic [15:0]                   status,
    output logic [15:0]                   start_condition_mask,
    output logic [15:0]                   idle_bit_times,
    // receive line events
    input  wire logic                     rx_valid,
    input  wire logic [7:0]               rx_data,
    input  wire logic                     rx_break,
    input  wire logic                     rx_line_idle,
    input  wire logic                     bit_tick,
    // frame output
    output logic                          flush,
    output logic                          frame_start,
    output logic                          frame_valid,
    output logic [7:0]                    frame_data,
    output logic                          frame_end
);

    if (SEQ_NUM != 4 || SEQ_LEN < 2 || SEQ_LEN > 8) begin : g_bad_geometry
        $error("rfs_receive_config: unsupported sequence geometry");
    end

    // ----------------------------------------
    // request handling
    // ----------------------------------------
    logic                         req_prev;
    logic                         req_edge;
    logic                         cfg_bad;
    logic [7:0]                   start_char;
    logic [7:0]                   end_char;
    logic [SEQ_NUM*8-1:0]         seq_ctl;
    logic [SEQ_NUM*SEQ_LEN*8-1:0] seq_chars;

    assign req_edge = frame_receive_command && !req_prev && !function_reinit_flag;
    assign cfg_bad  = ((cfg_start_condition_mask[7:0] & `RFS_SC_ANY) != 8'h00
                       && cfg_start_condition_mask[7:0] != `RFS_SC_ANY)
                      || cfg_start_condition_mask[7:0] == 8'h00
                      || cfg_start_condition_mask[15:8] != 8'h00;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            req_prev <= 1'b0;
        end else begin
            req_prev <= frame_receive_command;
        end
    end

    // set wins over the device's own clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            function_reinit_flag <= 1'b0;
        end else begin
            function_reinit_flag <= reinit_set;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            start_condition_mask <= `RFS_DEF_MASK;
            idle_bit_times       <= `RFS_DEF_IDLE;
            start_char           <= `RFS_DEF_START_CHAR;
            end_char             <= `RFS_DEF_END_CHAR;
            seq_ctl              <= {SEQ_NUM{`RFS_DEF_SEQ_CTL}};
            seq_chars            <= {(SEQ_NUM*SEQ_LEN){`RFS_DEF_SEQ_CHAR}};
        end else if (function_reinit_flag) begin
            start_condition_mask <= `RFS_DEF_MASK;
            idle_bit_times       <= `RFS_DEF_IDLE;
            start_char           <= `RFS_DEF_START_CHAR;
            end_char             <= `RFS_DEF_END_CHAR;
            seq_ctl              <= {SEQ_NUM{`RFS_DEF_SEQ_CTL}};
            seq_chars            <= {(SEQ_NUM*SEQ_LEN){`RFS_DEF_SEQ_CHAR}};
        end else if (req_edge && !cfg_bad) begin
            start_condition_mask <= cfg_start_condition_mask;
            idle_bit_times       <= cfg_idle_bit_times;
            start_char           <= cfg_start_char;
            end_char             <= cfg_end_char;
            seq_ctl              <= cfg_seq_ctl;
            seq_chars            <= cfg_seq_chars;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done   <= 1'b0;
            error  <= 1'b0;
            flush  <= 1'b0;
            status <= `RFS_STATUS_IDLE;
        end else begin
            done  <= req_edge && !cfg_bad;
            error <= req_edge && cfg_bad;
            flush <= (req_edge && !cfg_bad) || function_reinit_flag;
            if (function_reinit_flag) begin
                status <= `RFS_STATUS_IDLE;
            end else if (req_edge) begin
                status <= cfg_bad ? `RFS_STATUS_BAD_COND : `RFS_STATUS_OK;
            end
        end
    end

    // ----------------------------------------
    // start condition evaluation
    // ----------------------------------------
    logic                    clear_rx;
    logic                    en_char;
    logic                    en_any;
    logic                    en_brk;
    logic                    en_idle;
    logic [SEQ_NUM-1:0]      en_seq;
    logic                    brk_seen;
    logic                    idle_seen;
    logic [15:0]             idle_cnt;
    logic                    prereq_ok;
    logic                    char_hit;
    logic [SEQ_NUM-1:0]      seq_hit;
    logic                    go;
    logic [SEQ_LEN*8-1:0]    hist;
    logic [SEQ_LEN*8-1:0]    next_hist;
    rfs_pkg::rfs_rx_state_t  rx_state;

    assign clear_rx  = (req_edge && !cfg_bad) || function_reinit_flag;
    assign en_char   = (start_condition_mask[7:0] & `RFS_SC_CHAR) != 8'h00;
    assign en_any    = (start_condition_mask[7:0] & `RFS_SC_ANY) != 8'h00;
    assign en_brk    = (start_condition_mask[7:0] & `RFS_SC_BREAK) != 8'h00;
    assign en_idle   = (start_condition_mask[7:0] & `RFS_SC_IDLE) != 8'h00;
    assign en_seq    = start_condition_mask[`RFS_SC_SEQ_LSB +: SEQ_NUM];
    assign prereq_ok = (!en_brk || brk_seen) && (!en_idle || idle_seen);
    assign char_hit  = en_char && rx_data == start_char;
    assign next_hist = {hist[SEQ_LEN*8-9:0], rx_data};

    // position 1 of a sequence is the oldest character
    genvar s, p;
    generate
        for (s = 0; s < SEQ_NUM; s++) begin : g_seq
            logic [SEQ_LEN-1:0] pos_ok;
            for (p = 0; p < SEQ_LEN; p++) begin : g_pos
                assign pos_ok[p] = !seq_ctl[s*8+p]
                    || next_hist[(SEQ_LEN-1-p)*8 +: 8] == seq_chars[(s*SEQ_LEN+p)*8 +: 8];
            end
            assign seq_hit[s] = en_seq[s] && seq_ctl[s*8 +: SEQ_LEN] != '0 && &pos_ok;
        end
    endgenerate

    // with no char/sequence enabled the prerequisites alone start a frame
    assign go = rx_valid && (en_any
              || (prereq_ok && ((!en_char && en_seq == '0) || char_hit
                                || seq_hit != '0)));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            brk_seen <= 1'b0;
        end else if (clear_rx || (rx_state == rfs_pkg::RFS_HUNT && go)) begin
            brk_seen <= 1'b0;
        end else if (rx_break) begin
            brk_seen <= 1'b1;
        end
    end

    // with break enabled, idle counting starts only once the break is met
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            idle_cnt  <= 16'h0000;
            idle_seen <= 1'b0;
        end else if (clear_rx || rx_break || (rx_state == rfs_pkg::RFS_HUNT && go)) begin
            idle_cnt  <= 16'h0000;
            idle_seen <= 1'b0;
        end else if (!rx_line_idle || (en_brk && !brk_seen)) begin
            idle_cnt  <= 16'h0000;
        end else begin
            if (bit_tick && idle_cnt != 16'hFFFF) begin
                idle_cnt <= idle_cnt + 16'h0001;
            end
            if (idle_cnt >= idle_bit_times) begin
                idle_seen <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hist <= '0;
        end else if (clear_rx || (rx_state == rfs_pkg::RFS_HUNT && go)) begin
            hist <= '0;
        end else if (rx_valid && rx_state == rfs_pkg::RFS_HUNT) begin
            hist <= next_hist;
        end
    end

    // ----------------------------------------
    // frame reception
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_state    <= rfs_pkg::RFS_HUNT;
            frame_start <= 1'b0;
            frame_valid <= 1'b0;
            frame_data  <= 8'h00;
            frame_end   <= 1'b0;
        end else begin
            frame_start <= 1'b0;
            frame_valid <= 1'b0;
            frame_end   <= 1'b0;
            if (clear_rx) begin
                rx_state <= rfs_pkg::RFS_HUNT;
            end else if (rx_valid) begin
                unique case (rx_state)
                    rfs_pkg::RFS_HUNT: begin
                        if (go) begin
                            rx_state    <= rfs_pkg::RFS_FRAME;
                            frame_start <= 1'b1;
                            frame_valid <= 1'b1;
                            frame_data  <= rx_data;
                        end
                    end
                    rfs_pkg::RFS_FRAME: begin
                        frame_valid <= 1'b1;
                        frame_data  <= rx_data;
                        if (rx_data == end_char) begin
                            rx_state  <= rfs_pkg::RFS_HUNT;
                            frame_end <= 1'b1;
                        end
                    end
                    default: rx_state <= rfs_pkg::RFS_HUNT;
                endcase
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_edge_gives_answer: assert property (req_edge |=> (done ^ error))
        else $error("request edge not answered");
    a_level_no_apply: assert property (
        $past(frame_receive_command) && frame_receive_command |=> !done && !error)
        else $error("held request answered again");
    a_apply_flushes: assert property (done |-> flush && rx_state == rfs_pkg::RFS_HUNT)
        else $error("apply did not discard data");
    a_reinit_defaults: assert property (function_reinit_flag && !reinit_set |=>
        !function_reinit_flag && status == `RFS_STATUS_IDLE
        && start_condition_mask == `RFS_DEF_MASK)
        else $error("reinit did not restore defaults");
    a_done_single: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_error_code: assert property (error |-> status == `RFS_STATUS_BAD_COND ##1 !error)
        else $error("error pulse or code wrong");
    a_bad_keeps_cfg: assert property (req_edge && cfg_bad |=>
        start_condition_mask == $past(start_condition_mask))
        else $error("rejected request changed settings");
    a_any_alone: assert property (en_any |-> start_condition_mask[7:0] == `RFS_SC_ANY)
        else $error("any-character combined");
    a_break_then_idle: assert property (
        frame_start && $past(en_brk && en_idle && !clear_rx)
        |-> $past(brk_seen) && $past(idle_seen))
        else $error("frame started before break and idle");

    c_done:        cover property (done);
    c_error:       cover property (error);
    c_brk_idle:    cover property (frame_start && $past(en_brk && en_idle));
    c_frame_end:   cover property (frame_end);

endmodule : rfs_receive_config

// *** rtl/rfs_defs.svh ***
// constants of the receive frame start configuration block
`ifndef RFS_DEFS_SVH
`define RFS_DEFS_SVH

// ----------------------------------------
// start condition mask bits
// ----------------------------------------
`define RFS_SC_CHAR         8'h01
`define RFS_SC_ANY          8'h02
`define RFS_SC_BREAK        8'h04
`define RFS_SC_IDLE         8'h08
`define RFS_SC_SEQ_LSB      4

// ----------------------------------------
// stored defaults
// ----------------------------------------
`define RFS_DEF_MASK        16'h0002
`define RFS_DEF_IDLE        16'h0028
`define RFS_DEF_START_CHAR  8'h02
`define RFS_DEF_END_CHAR    8'h03
`define RFS_DEF_SEQ_CTL     8'h00
`define RFS_DEF_SEQ_CHAR    8'h00

// ----------------------------------------
// status codes
// ----------------------------------------
`define RFS_STATUS_IDLE     16'h7000
`define RFS_STATUS_OK       16'h0000
`define RFS_STATUS_BAD_COND 16'h8201

`endif

// *** rtl/rfs_pkg.sv ***
// types of the receive frame start configuration block
package rfs_pkg;

    typedef enum logic [1:0] {
        RFS_HUNT  = 2'b01,
        RFS_FRAME = 2'b10
    } rfs_rx_state_t;

endpackage : rfs_pkg

// *** bench/rfs_host_model.sv ***
// host side model issuing receive configuration requests
`timescale 1ns/1ps

module rfs_host_model (
    // clock
    input  wire logic          core_clk,
    // request side
    output logic               frame_receive_command,
    output logic               reinit_set,
    output logic [15:0]        cfg_start_condition_mask,
    output logic [15:0]        cfg_idle_bit_times,
    output logic [7:0]         cfg_start_char,
    output logic [7:0]         cfg_end_char,
    output logic [31:0]        cfg_seq_ctl,
    output logic [159:0]       cfg_seq_chars
);
    initial begin
        frame_receive_command    = 1'b0;
        reinit_set               = 1'b0;
        cfg_start_condition_mask = 16'h0002;
        cfg_idle_bit_times       = 16'h0028;
        cfg_start_char           = 8'h02;
        cfg_end_char             = 8'h03;
        cfg_seq_ctl              = 32'h0;
        cfg_seq_chars            = 160'h0;
    end

    // ----------------------------------------
    // one request, command held for hold cycles
    // ----------------------------------------
    task automatic request(input logic [15:0] mask, input logic [15:0] idle, input int hold);
        @(negedge core_clk);
        cfg_start_condition_mask = mask;
        cfg_idle_bit_times       = idle;
        frame_receive_command    = 1'b1;
        repeat (hold) @(negedge core_clk);
        frame_receive_command    = 1'b0;
        // released fields no longer show the last value
        cfg_start_condition_mask = ~mask;
        cfg_idle_bit_times       = ~idle;
    endtask : request

    // ----------------------------------------
    // set the reinit flag for one cycle
    // ----------------------------------------
    task automatic reinit();
        @(negedge core_clk);
        reinit_set = 1'b1;
        @(negedge core_clk);
        reinit_set = 1'b0;
    endtask : reinit

    // ----------------------------------------
    // load the start sequence fields
    // ----------------------------------------
    task automatic set_seq(input logic [31:0] ctl, input logic [159:0] chars);
        @(negedge core_clk);
        cfg_seq_ctl   = ctl;
        cfg_seq_chars = chars;
    endtask : set_seq
endmodule : rfs_host_model

// *** bench/rfs_receive_config_tb.sv ***
// self-checking bench of the receive configuration block
`timescale 1ns/1ps
`include "rfs_defs.svh"
`define CHK(name, exp, got) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
end

module rfs_receive_config_tb;
    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] idle;
        logic        err;
    } rfs_row_t;

    logic           core_clk = 1'b0;
    logic           rstn     = 1'b0;
    logic           frame_receive_command, reinit_set, function_reinit_flag;
    logic [15:0]    cfg_start_condition_mask, cfg_idle_bit_times, status;
    logic [15:0]    start_condition_mask, idle_bit_times, exp_mask, exp_idle;
    logic [7:0]     cfg_start_char, cfg_end_char, rx_data = 8'h00, frame_data;
    logic [31:0]    cfg_seq_ctl;
    logic [159:0]   cfg_seq_chars;
    logic           done, error, flush, frame_start, frame_valid, frame_end;
    logic           rx_valid = 1'b0, rx_break = 1'b0, rx_line_idle = 1'b0, bit_tick = 1'b0;
    int             errors = 0, checks = 0, cycles = 0;
    rfs_row_t       rows [8] = '{'{16'h0001, 16'h0010, 1'b0}, '{16'h0003, 16'h0011, 1'b1},
                                 '{16'h0000, 16'h0012, 1'b1}, '{16'h0102, 16'h0013, 1'b1},
                                 '{16'h00F1, 16'h0FFF, 1'b0}, '{16'h000A, 16'h0014, 1'b1},
                                 '{16'h000D, 16'hFFFF, 1'b0}, '{16'h0002, 16'h0000, 1'b0}};

    always #10 core_clk = ~core_clk;

    rfs_host_model host (.core_clk(core_clk), .frame_receive_command(frame_receive_command),
        .reinit_set(reinit_set), .cfg_start_condition_mask(cfg_start_condition_mask),
        .cfg_idle_bit_times(cfg_idle_bit_times), .cfg_start_char(cfg_start_char),
        .cfg_end_char(cfg_end_char), .cfg_seq_ctl(cfg_seq_ctl), .cfg_seq_chars(cfg_seq_chars));

    rfs_receive_config dut (.core_clk(core_clk), .rstn(rstn),
        .frame_receive_command(frame_receive_command), .reinit_set(reinit_set),
        .cfg_start_condition_mask(cfg_start_condition_mask),
        .cfg_idle_bit_times(cfg_idle_bit_times), .cfg_start_char(cfg_start_char),
        .cfg_end_char(cfg_end_char), .cfg_seq_ctl(cfg_seq_ctl), .cfg_seq_chars(cfg_seq_chars),
        .function_reinit_flag(function_reinit_flag), .done(done), .error(error),
        .status(status), .start_condition_mask(start_condition_mask),
        .idle_bit_times(idle_bit_times), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_break(rx_break), .rx_line_idle(rx_line_idle), .bit_tick(bit_tick), .flush(flush),
        .frame_start(frame_start), .frame_valid(frame_valid), .frame_data(frame_data),
        .frame_end(frame_end));

    // ----------------------------------------
    // line stimulus and frame checks
    // ----------------------------------------
    task automatic rx_check(input logic [7:0] d, input logic st, input logic en);
        @(negedge core_clk);
        rx_valid = 1'b1;
        rx_data  = d;
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_data  = ~d;
        `CHK("frame_start", st, frame_start)
        `CHK("frame_end", en, frame_end)
        `CHK("frame_valid", st || en, frame_valid)
        if (st || en) `CHK("frame_data", d, frame_data)
    endtask : rx_check

    task automatic idle_ticks(input int n);
        rx_line_idle = 1'b1;
        repeat (n) begin
            @(negedge core_clk);
            bit_tick = 1'b1;
            @(negedge core_clk);
            bit_tick = 1'b0;
        end
        repeat (2) @(negedge core_clk);
        rx_line_idle = 1'b0;
    endtask : idle_ticks

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        `CHK("status", `RFS_STATUS_IDLE, status)
        `CHK("mask", `RFS_DEF_MASK, start_condition_mask)
        `CHK("idle", `RFS_DEF_IDLE, idle_bit_times)
        rx_check(8'h41, 1'b1, 1'b0);
        rx_check(8'h03, 1'b0, 1'b1);
        exp_mask = `RFS_DEF_MASK;
        exp_idle = `RFS_DEF_IDLE;
        foreach (rows[i]) begin
            host.request(rows[i].mask, rows[i].idle, 1);
            `CHK("done", ~rows[i].err, done)
            `CHK("error", rows[i].err, error)
            `CHK("flush", ~rows[i].err, flush)
            if (!rows[i].err) begin
                exp_mask = rows[i].mask;
                exp_idle = rows[i].idle;
            end
            `CHK("status", rows[i].err ? `RFS_STATUS_BAD_COND : `RFS_STATUS_OK, status)
            `CHK("mask", exp_mask, start_condition_mask)
            `CHK("idle", exp_idle, idle_bit_times)
        end
        host.request(16'h0001, 16'h0003, 4);
        `CHK("done", 1'b0, done)
        `CHK("mask", 16'h0001, start_condition_mask)
        rx_check(8'h41, 1'b0, 1'b0);
        rx_check(8'h02, 1'b1, 1'b0);
        rx_check(8'h03, 1'b0, 1'b1);
        host.request(16'h000D, 16'h0003, 1);
        `CHK("done", 1'b1, done)
        rx_check(8'h02, 1'b0, 1'b0);
        idle_ticks(4);
        @(negedge core_clk);
        rx_break = 1'b1;
        @(negedge core_clk);
        rx_break = 1'b0;
        rx_check(8'h02, 1'b0, 1'b0);
        idle_ticks(4);
        rx_check(8'h02, 1'b1, 1'b0);
        rx_check(8'h03, 1'b0, 1'b1);
        host.set_seq(32'h0000001F, {120'h0, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41});
        host.request(16'h0010, 16'h0003, 1);
        `CHK("done", 1'b1, done)
        rx_check(8'h41, 1'b0, 1'b0);
        rx_check(8'h42, 1'b0, 1'b0);
        rx_check(8'h58, 1'b0, 1'b0);
        rx_check(8'h41, 1'b0, 1'b0);
        rx_check(8'h42, 1'b0, 1'b0);
        rx_check(8'h43, 1'b0, 1'b0);
        rx_check(8'h44, 1'b0, 1'b0);
        rx_check(8'h45, 1'b1, 1'b0);
        rx_check(8'h03, 1'b0, 1'b1);
        host.reinit();
        `CHK("reinit_flag", 1'b1, function_reinit_flag)
        @(negedge core_clk);
        `CHK("reinit_flag", 1'b0, function_reinit_flag)
        `CHK("flush", 1'b1, flush)
        `CHK("status", `RFS_STATUS_IDLE, status)
        `CHK("mask", `RFS_DEF_MASK, start_condition_mask)
        host.request(16'h0001, 16'h0022, 1);
        rstn = 1'b0;
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        `CHK("mask", `RFS_DEF_MASK, start_condition_mask)
        `CHK("idle", `RFS_DEF_IDLE, idle_bit_times)
        host.request(16'h0001, 16'h0022, 1);
        `CHK("mask", 16'h0001, start_condition_mask)
        print_verdict();
    end
endmodule : rfs_receive_config_tb
